// *** hdl/ddc_pkg.sv ***
// Package of register map, field layout and constants for the DDC channel
package ddc_pkg;
  localparam int          SW           = 16;
  localparam int          NCO_W        = 48;
  localparam int          LUT_AW       = 4;
  localparam int          N_SETS       = 16;
  localparam int          SEL_W        = 4;
  localparam int          AW           = 6;
  // Byte addresses of the register words
  localparam logic [AW-1:0] A_CTRL     = 6'h00;
  localparam logic [AW-1:0] A_NCOSEL   = 6'h04;
  localparam logic [AW-1:0] A_TW_LO    = 6'h08;
  localparam logic [AW-1:0] A_TW_HI    = 6'h0C;
  localparam logic [AW-1:0] A_PO_LO    = 6'h10;
  localparam logic [AW-1:0] A_PO_HI    = 6'h14;
  localparam logic [AW-1:0] A_MA_LO    = 6'h18;
  localparam logic [AW-1:0] A_MA_HI    = 6'h1C;
  localparam logic [AW-1:0] A_MB_LO    = 6'h20;
  localparam logic [AW-1:0] A_MB_HI    = 6'h24;
  localparam logic [AW-1:0] A_STATUS   = 6'h28;
  localparam logic [AW-1:0] A_SOFTRST  = 6'h2C;
  // Control register fields
  localparam int          C_GAIN_BIT   = 0;
  localparam int          C_DEC_LSB    = 1;
  localparam int          C_C2R_BIT    = 3;
  localparam int          C_IF_LSB     = 4;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  // Select register fields: [3:0] index, [7:4] source, [11:8] write index
  localparam int          S_IDX_LSB    = 0;
  localparam int          S_SRC_LSB    = 4;
  localparam int          S_WIDX_LSB   = 8;
  localparam logic [15:0] FULL_SCALE   = 16'h7FDF; // 0.999 of +full scale
  localparam logic [15:0] HI_MASK      = 16'hFFFF;
  localparam logic [31:0] BAD_READ     = 32'hDEAD_0000;
  localparam logic [1:0]  RESP_OK      = 2'h0;
  localparam logic [1:0]  RESP_DECERR  = 2'h3;

  typedef enum logic [1:0] {
    IF_VARIABLE,
    IF_ZERO,
    IF_QUARTER,
    IF_TEST
  } ddc_if_e;
endpackage : ddc_pkg

// *** hdl/ddc_channel.sv ***
// One DDC channel: NCO, quadrature mixer, decimator, gain, fs/4 complex-to-real
module ddc_channel
  import ddc_pkg::*;
#(
  parameter int DEC_STAGES = 3
) (
  // Clock, reset, enable
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  // Avalon-MM slave
  input  wire logic [ddc_pkg::AW-1:0] avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [3:0]           avs_byteenable_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic      [31:0]          avs_readdata_o,
  output logic      [1:0]           avs_response_o,
  output logic                      avs_waitrequest_o,
  // Sync and shadow-set select pins
  input  wire logic                 sysref_i,
  input  wire logic [ddc_pkg::SEL_W-1:0] gpio_sel_i,
  // Sample stream from ADC core
  input  wire logic                 in_valid_i,
  input  wire logic [ddc_pkg::SW-1:0] in_i_i,
  input  wire logic [ddc_pkg::SW-1:0] in_q_i,
  // Sample stream to output framer
  output logic                      out_valid_o,
  output logic      [ddc_pkg::SW-1:0] out_i_o,
  output logic      [ddc_pkg::SW-1:0] out_q_o
);
  import ddc_pkg::*;
  logic [31:0]       ctrl_q, nsel_q;
  logic [NCO_W-1:0]  tw_q [N_SETS];
  logic [NCO_W-1:0]  po_q [N_SETS];
  logic [NCO_W-1:0]  ma_q, mb_q;
  logic              ack_q;
  logic [31:0]       rdata_q;
  logic [1:0]        resp_q;
  logic              sync_req;
  logic [2:0]        sref_q;
  logic [SEL_W-1:0]  gsel_s1, gsel_s2;
  ddc_if_e           if_mode;
  logic              c2r_en, gain6, mod_en;
  logic [SEL_W-1:0]  act_idx, widx;
  logic [NCO_W-1:0]  acc_q, frac_q, tw_act, po_act, phase;
  logic [NCO_W:0]    frac_sum, frac_wrap;
  logic              carry;
  logic [1:0]        quad_q;
  assign if_mode = ddc_if_e'(ctrl_q[C_IF_LSB +: 2]);
  assign c2r_en  = ctrl_q[C_C2R_BIT];
  assign gain6   = ctrl_q[C_GAIN_BIT];
  assign mod_en  = (ma_q != '0);
  assign widx    = nsel_q[S_WIDX_LSB +: SEL_W];
  // Write data merged under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction : merge
  function automatic logic [NCO_W-1:0] set_half(input logic [NCO_W-1:0] old,
                                                input logic [31:0] nw, input logic [3:0] be,
                                                input logic hi);
    logic [NCO_W-1:0] r;
    logic [31:0]      t;
    r = old;
    t = merge({16'h0000, old[NCO_W-1:32]}, nw, be);
    if (hi) r[NCO_W-1:32] = t[NCO_W-33:0];
    else r[31:0] = merge(old[31:0], nw, be);
    return r;
  endfunction : set_half
  logic wr, rd;
  assign wr = avs_write_i && !ack_q;
  assign rd = avs_read_i && !ack_q;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign avs_readdata_o    = rdata_q;
  assign avs_response_o    = resp_q;
  // One wait state per access
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= (rd || wr);
    end
  end
  // Register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      nsel_q <= '0;
      ma_q   <= '0;
      mb_q   <= '0;
      for (int k = 0; k < N_SETS; k++) begin
        tw_q[k] <= '0;
        po_q[k] <= '0;
      end
    end else if (ce_i && wr) begin
      case (avs_address_i)
        A_CTRL:   ctrl_q <= merge(ctrl_q, avs_writedata_i, avs_byteenable_i);
        A_NCOSEL: nsel_q <= merge(nsel_q, avs_writedata_i, avs_byteenable_i);
        // Tuning and phase sets may change at any time; accumulator runs on
        A_TW_LO:  tw_q[widx] <= set_half(tw_q[widx], avs_writedata_i,
                                         avs_byteenable_i, 1'b0);
        A_TW_HI:  tw_q[widx] <= set_half(tw_q[widx], avs_writedata_i,
                                         avs_byteenable_i, 1'b1);
        A_PO_LO:  po_q[widx] <= set_half(po_q[widx], avs_writedata_i,
                                         avs_byteenable_i, 1'b0);
        A_PO_HI:  po_q[widx] <= set_half(po_q[widx], avs_writedata_i,
                                         avs_byteenable_i, 1'b1);
        A_MA_LO:  ma_q <= set_half(ma_q, avs_writedata_i, avs_byteenable_i, 1'b0);
        A_MA_HI:  ma_q <= set_half(ma_q, avs_writedata_i, avs_byteenable_i, 1'b1);
        A_MB_LO:  mb_q <= set_half(mb_q, avs_writedata_i, avs_byteenable_i, 1'b0);
        A_MB_HI:  mb_q <= set_half(mb_q, avs_writedata_i, avs_byteenable_i, 1'b1);
        default: ;
      endcase
    end
  end
  // Register reads
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
      resp_q  <= RESP_OK;
    end else if (ce_i && (rd || wr)) begin
      resp_q  <= RESP_OK;
      rdata_q <= '0;
      case (avs_address_i)
        A_CTRL:    rdata_q <= ctrl_q;
        A_NCOSEL:  rdata_q <= nsel_q;
        A_TW_LO:   rdata_q <= tw_q[widx][31:0];
        A_TW_HI:   rdata_q <= {16'h0000, tw_q[widx][NCO_W-1:32]};
        A_PO_LO:   rdata_q <= po_q[widx][31:0];
        A_PO_HI:   rdata_q <= {16'h0000, po_q[widx][NCO_W-1:32]};
        A_MA_LO:   rdata_q <= ma_q[31:0];
        A_MA_HI:   rdata_q <= {16'h0000, ma_q[NCO_W-1:32]};
        A_MB_LO:   rdata_q <= mb_q[31:0];
        A_MB_HI:   rdata_q <= {16'h0000, mb_q[NCO_W-1:32]};
        A_STATUS:  rdata_q <= {24'h000000, mod_en, 3'h0, act_idx};
        A_SOFTRST: rdata_q <= '0;
        default: begin
          rdata_q <= rd ? BAD_READ : '0;
          resp_q  <= RESP_DECERR;
        end
      endcase
    end
  end
  // Sync input and select pins through two flops; edge on the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sref_q  <= '0;
      gsel_s1 <= '0;
      gsel_s2 <= '0;
    end else if (ce_i) begin
      sref_q  <= {sref_q[1:0], sysref_i};
      gsel_s1 <= gpio_sel_i;
      gsel_s2 <= gsel_s1;
    end
  end
  assign sync_req = (sref_q[1] && !sref_q[2]) ||
                    (wr && (avs_address_i == A_SOFTRST) && avs_writedata_i[0]);
  assign act_idx  = (nsel_q[S_SRC_LSB +: 4] == 4'h0) ? nsel_q[S_IDX_LSB +: SEL_W] : gsel_s2;
  assign tw_act   = tw_q[act_idx];
  assign po_act   = po_q[act_idx];
  // Modulus fraction: accumulate numerator, wrap at denominator, carry one step
  assign frac_sum = {1'b0, frac_q} + {1'b0, ma_q};
  assign frac_wrap = frac_sum - {1'b0, mb_q};
  assign carry    = mod_en && (frac_sum >= {1'b0, mb_q});
  // Phase accumulator, cleared on resync
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q  <= '0;
      frac_q <= '0;
      quad_q <= '0;
    end else if (ce_i) begin
      if (sync_req) begin
        acc_q  <= '0;
        frac_q <= '0;
        quad_q <= '0;
      end else if (in_valid_i) begin
        acc_q  <= acc_q + tw_act + {{(NCO_W-1){1'b0}}, carry};
        frac_q <= !mod_en ? '0 : carry ? frac_wrap[NCO_W-1:0]
                                       : frac_sum[NCO_W-1:0];
        quad_q <= quad_q + 2'h1;
      end
    end
  end
  assign phase = acc_q + po_act;
  // Quarter-wave sine table on 4 phase bits of the top quadrant
  function automatic logic signed [SW-1:0] sin_lut(input logic [LUT_AW+1:0] p);
    logic [LUT_AW-1:0] a;
    logic [SW-1:0]     m;
    a = p[LUT_AW] ? ~p[LUT_AW-1:0] : p[LUT_AW-1:0];
    case (a)
      4'h0: m = 16'h0000; 4'h1: m = 16'h0C8B; 4'h2: m = 16'h18F8; 4'h3: m = 16'h2527;
      4'h4: m = 16'h30FB; 4'h5: m = 16'h3C56; 4'h6: m = 16'h471C; 4'h7: m = 16'h5133;
      4'h8: m = 16'h5A82; 4'h9: m = 16'h62F1; 4'hA: m = 16'h6A6D; 4'hB: m = 16'h70E2;
      4'hC: m = 16'h7641; 4'hD: m = 16'h7A7C; 4'hE: m = 16'h7D89; 4'hF: m = 16'h7F61;
      default: m = 16'h0000;
    endcase
    return p[LUT_AW+1] ? -signed'(m) : signed'(m);
  endfunction : sin_lut
  logic [LUT_AW+1:0] ph_top;
  logic signed [SW-1:0] nco_cos, nco_sin, src_i, src_q, mix_i, mix_q;
  logic signed [2*SW:0] prod_i, prod_q;
  assign ph_top  = phase[NCO_W-1 -: LUT_AW+2];
  assign nco_sin = sin_lut(ph_top);
  assign nco_cos = sin_lut(ph_top + 6'h10);

  // Source selection and mixing per IF mode
  always_comb begin
    src_i  = signed'(in_i_i);
    src_q  = signed'(in_q_i);
    prod_i = '0;
    prod_q = '0;
    mix_i  = src_i;
    mix_q  = src_q;
    case (if_mode)
      IF_ZERO: begin
        mix_i = src_i;
        mix_q = src_q;
      end
      IF_QUARTER: begin
        // Multiply by exp(-j*pi/2*n): only swaps and negations
        case (quad_q)
          2'h0: begin mix_i = src_i;  mix_q = src_q;  end
          2'h1: begin mix_i = src_q;  mix_q = -src_i; end
          2'h2: begin mix_i = -src_i; mix_q = -src_q; end
          default: begin mix_i = -src_q; mix_q = src_i; end
        endcase
      end
      default: begin
        if (if_mode == IF_TEST) begin
          src_i = signed'(FULL_SCALE);
          src_q = '0;
        end
        // (I + jQ)(cos - j sin)
        prod_i = src_i * nco_cos + src_q * nco_sin;
        prod_q = src_q * nco_cos - src_i * nco_sin;
        mix_i  = prod_i[2*SW-2 -: SW];
        mix_q  = prod_q[2*SW-2 -: SW];
      end
    endcase
  end

  // Decimating cascade: pairwise-average half-band approximation per stage
  logic signed [SW-1:0] st_i [DEC_STAGES+1];
  logic signed [SW-1:0] st_q [DEC_STAGES+1];
  logic                 st_v [DEC_STAGES+1];
  logic [DEC_STAGES-1:0] ph_q;
  logic signed [SW-1:0] hold_i [DEC_STAGES];
  logic signed [SW-1:0] hold_q [DEC_STAGES];
  logic signed [SW-1:0] dec_i [DEC_STAGES];
  logic signed [SW-1:0] dec_q [DEC_STAGES];
  logic                 dec_v [DEC_STAGES];
  assign st_i[0] = mix_i;
  assign st_q[0] = mix_q;
  assign st_v[0] = in_valid_i && !sync_req;

  for (genvar s = 0; s < DEC_STAGES; s++) begin : g_dec
    logic signed [SW:0] sum_i, sum_q;
    assign sum_i = st_i[s] + hold_i[s];
    assign sum_q = st_q[s] + hold_q[s];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        ph_q[s]   <= 1'b0;
        hold_i[s] <= '0;
        hold_q[s] <= '0;
        dec_i[s]  <= '0;
        dec_q[s]  <= '0;
        dec_v[s]  <= 1'b0;
      end else if (ce_i) begin
        dec_v[s] <= st_v[s] && ph_q[s];
        if (sync_req) begin
          ph_q[s] <= 1'b0;
        end else if (st_v[s]) begin
          ph_q[s] <= !ph_q[s];
          if (!ph_q[s]) begin
            hold_i[s] <= st_i[s];
            hold_q[s] <= st_q[s];
          end else begin
            dec_i[s] <= sum_i[SW:1];
            dec_q[s] <= sum_q[SW:1];
          end
        end
      end
    end
    assign st_i[s+1] = dec_i[s];
    assign st_q[s+1] = dec_q[s];
    assign st_v[s+1] = dec_v[s];
  end

  // Gain, then optional fs/4 complex-to-real with output registers
  logic signed [SW-1:0] g_i, g_q, r_val;
  logic signed [SW:0]   r_sum;
  logic [1:0]           rq_q;
  logic signed [SW-1:0] r_prev_q;
  function automatic logic signed [SW-1:0] dbl(input logic signed [SW-1:0] x);
    if (x[SW-1] != x[SW-2]) return x[SW-1] ? signed'(~HI_MASK >> 1 | 16'h8000)
                                          : signed'(HI_MASK >> 1);
    return {x[SW-2:0], 1'b0};
  endfunction : dbl
  assign g_i = gain6 ? dbl(st_i[DEC_STAGES]) : st_i[DEC_STAGES];
  assign g_q = gain6 ? dbl(st_q[DEC_STAGES]) : st_q[DEC_STAGES];
  always_comb begin
    // Real part of (I+jQ)exp(j*pi/2*n)
    case (rq_q)
      2'h0:    r_val = g_i;
      2'h1:    r_val = -g_q;
      2'h2:    r_val = -g_i;
      default: r_val = g_q;
    endcase
  end
  assign r_sum = r_val + r_prev_q; // Two-tap filter removes image

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      out_i_o     <= '0;
      out_q_o     <= '0;
      rq_q        <= '0;
      r_prev_q    <= '0;
    end else if (ce_i) begin
      out_valid_o <= st_v[DEC_STAGES];
      if (sync_req) begin
        rq_q <= '0;
      end else if (st_v[DEC_STAGES]) begin
        if (c2r_en) begin
          rq_q     <= rq_q + 2'h1;
          r_prev_q <= r_val;
          out_i_o  <= r_sum[SW:1];
          out_q_o  <= '0;
        end else begin
          out_i_o <= g_i;
          out_q_o <= g_q;
        end
      end
    end
  end
endmodule : ddc_channel

// *** sim/ddc_channel_asserts.sv ***
// Checker for the DDC channel bus handshake and decimated output stream
module ddc_channel_asserts #(
  parameter int DEC_STAGES = 3
) (
  // Clock and reset
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   ce_i,
  // Register bus
  input wire logic [ddc_pkg::AW-1:0] avs_address_i,
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic [31:0]            avs_readdata_o,
  input wire logic [1:0]             avs_response_o,
  input wire logic                   avs_waitrequest_o,
  // Sample streams
  input wire logic                   in_valid_i,
  input wire logic                   out_valid_o,
  input wire logic [ddc_pkg::SW-1:0] out_i_o,
  input wire logic [ddc_pkg::SW-1:0] out_q_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_pkg::*;
  localparam int DEC = 1 << DEC_STAGES;
  logic        unmapped;
  logic [15:0] gap_q;
  logic [15:0] idle_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  assign unmapped = (avs_address_i > A_SOFTRST) || (avs_address_i[1:0] != 2'h0);
  // Cycles since the last output pulse and since the last input sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q <= 16'hFFFF;
    end else if (out_valid_o) begin
      gap_q <= 16'h0001;
    end else if (gap_q != 16'hFFFF) begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_q <= 16'hFFFF;
    end else if (in_valid_i) begin
      idle_q <= 16'h0000;
    end else if (idle_q != 16'hFFFF) begin
      idle_q <= idle_q + 16'h0001;
    end
  end
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
  endsequence
  sequence s_done;
    (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  endsequence
  property p_one_wait;
    s_taken |=> s_done;
  endproperty
  property p_idle_free;
    !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o;
  endproperty
  property p_refused;
    s_done ##0 unmapped |-> avs_response_o == RESP_DECERR
      && (avs_write_i || avs_readdata_o == BAD_READ);
  endproperty
  property p_mapped_ok;
    s_done ##0 !unmapped |-> avs_response_o == RESP_OK;
  endproperty
  property p_read_stands;
    $changed(avs_readdata_o) || $changed(avs_response_o) |-> s_done;
  endproperty
  property p_out_spacing;
    out_valid_o |-> gap_q >= 16'(DEC);
  endproperty
  property p_recent_input;
    out_valid_o |-> idle_q < 16'h0010;
  endproperty
  property p_out_hold;
    $changed(out_i_o) || $changed(out_q_o) |-> out_valid_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
  a_idle_free: assert property (p_idle_free) else $error("wait without request");
  a_refused: assert property (p_refused) else $error("unmapped access accepted");
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
  a_read_stands: assert property (p_read_stands) else $error("read data moved");
  a_out_spacing: assert property (p_out_spacing) else $error("decimation too fast");
  a_recent_input: assert property (p_recent_input) else $error("output without input");
  a_out_hold: assert property (p_out_hold) else $error("output moved off valid");
endmodule : ddc_channel_asserts

bind ddc_channel ddc_channel_asserts #(.DEC_STAGES(DEC_STAGES)) ddc_channel_asserts_inst (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
  .in_valid_i(in_valid_i), .out_valid_o(out_valid_o), .out_i_o(out_i_o), .out_q_o(out_q_o)
);

// *** sim/ddc_adc_model.sv ***
// Sample source standing in for the converter core, with optional stalls
module ddc_adc_model (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Sample values and pacing from the bench
  input  wire logic [ddc_pkg::SW-1:0] smp_i_i,
  input  wire logic [ddc_pkg::SW-1:0] smp_q_i,
  input  wire logic                   slow_i,
  // Stream into the channel
  output logic                        valid_o,
  output logic      [ddc_pkg::SW-1:0] data_i_o,
  output logic      [ddc_pkg::SW-1:0] data_q_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_pkg::*;
  logic tog_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_q <= 1'b0;
      valid_o <= 1'b0;
      data_i_o <= '0;
      data_q_o <= '0;
    end else begin
      tog_q <= ~tog_q;
      valid_o <= !slow_i || tog_q;
      if (!slow_i || tog_q) begin
        data_i_o <= smp_i_i;
        data_q_o <= smp_q_i;
      end else begin
        // Gap cycles show no stale sample
        data_i_o <= ~data_i_o;
        data_q_o <= ~data_q_o;
      end
    end
  end
endmodule : ddc_adc_model

// *** sim/test_ddc_nco_frequency_translation.sv ***
// Self-checking bench for one DDC channel: registers, IF modes and decimated stream
module test_ddc_nco_frequency_translation;
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_pkg::*;
  logic             clk_i, rst_n_i, rd, wr, wreq, vld, ov, slow, sysref;
  logic [AW-1:0]    adr;
  logic [31:0]      wd, rdat, rv, rs, r;
  logic [1:0]       resp, rr;
  logic [SEL_W-1:0] gsel, sel;
  logic [SW-1:0]    si, sq, di, dq, oi, oq, oi_c, oq_c;
  logic [47:0]      tw [4];
  int               err_total, comparisons;
  int               hi_q[$], hq_q[$];
  ddc_channel #(.DEC_STAGES(3)) ddc_channel_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'hF), .avs_writedata_i(wd), .avs_readdata_o(rdat),
    .avs_response_o(resp), .avs_waitrequest_o(wreq), .sysref_i(sysref), .gpio_sel_i(gsel),
    .in_valid_i(vld), .in_i_i(di), .in_q_i(dq), .out_valid_o(ov), .out_i_o(oi), .out_q_o(oq));
  ddc_adc_model ddc_adc_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .smp_i_i(si),
    .smp_q_i(sq), .slow_i(slow), .valid_o(vld), .data_i_o(di), .data_q_o(dq));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Reference history of the last eight accepted samples
  always @(posedge clk_i) begin
    if (vld === 1'b1) begin
      hi_q.push_back(int'($signed(di)));
      hq_q.push_back(int'($signed(dq)));
    end
    if (hi_q.size() > 8) begin
      hi_q = hi_q[1:$];
      hq_q = hq_q[1:$];
    end
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic int mag(input logic [15:0] v);
    return v[15] ? -int'($signed(v)) : int'($signed(v));
  endfunction : mag
  function automatic logic [15:0] avg(input bit q, input bit g);
    int s = 0;
    for (int k = 0; k < 8; k++) s += q ? hq_q[k] : hi_q[k];
    return 16'((s / 8) * (g ? 2 : 1));
  endfunction : avg
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    {wr, rd, adr, wd} <= {w, !w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 64);
    rv = rdat;
    rr = resp;
    {wr, rd} <= 2'b00;
    if (n >= 64) chk(0, 1, "bus timeout");
  endtask : bus
  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(rv & m, exp, "register read");
  endtask : rdchk
  task automatic wset(input logic [3:0] k, input logic [47:0] t, input logic [47:0] p);
    bus(1'b1, A_NCOSEL, {20'h0, k, 4'h0, k});
    bus(1'b1, A_TW_LO, t[31:0]);
    bus(1'b1, A_TW_HI, {16'h0, t[47:32]});
    bus(1'b1, A_PO_LO, p[31:0]);
    bus(1'b1, A_PO_HI, {16'h0, p[47:32]});
  endtask : wset
  task automatic get_out();
    int n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ov !== 1'b1 && n < 200);
    {oi_c, oq_c} = {oi, oq};
    if (n >= 200) chk(0, 1, "no output sample");
  endtask : get_out
  // Kind 0 exact average, 1 tone cancelled, 2 and 3 strong I
  task automatic stream(input logic [31:0] ctl, input logic [15:0] a, input logic [15:0] b,
                        input int kind);
    bus(1'b1, A_CTRL, ctl);
    {si, sq} <= {a, b};
    repeat (4) get_out();
    for (int k = 0; k < 3; k++) begin
      get_out();
      if (kind == 0) chk({oi_c, oq_c}, {avg(0, ctl[0]), avg(1, ctl[0])}, "sample");
      if (kind == 1) chk(mag(oi_c) < 256 && mag(oq_c) < 256, 1, "tone left");
      if (kind >= 2) chk(mag(oi_c) >= 16'h0800, 1, "mix too small");
    end
    $display("test ctrl %h kind %0d done", ctl, kind);
  endtask : stream
  task automatic conclude();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    rs = 32'h0000_0032;
    {rd, wr, slow, sysref, rst_n_i, adr, wd, gsel, si, sq} = '0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdchk(A_CTRL, CTRL_RST, 32'hFFFF_FFFF);
    rdchk(A_STATUS, 32'h0, 32'h8F);
    bus(1'b1, 6'h30, 32'h35);
    chk(32'(rr), 32'(RESP_DECERR), "refused write");
    rdchk(6'h31, BAD_READ, 32'hFFFF_FFFF);
    rdchk(A_CTRL, CTRL_RST, 32'hFFFF_FFFF);
    $display("test reset and refused access done");
    tw[0] = 48'h8000_0000_0000;
    tw[1] = 48'h0;
    tw[2] = 48'h7FFF_FFFF_FFFF;
    tw[3] = 48'({rnd(), rnd()});
    for (int k = 0; k < 4; k++) begin
      sel = 4'(rnd());
      wset(sel, tw[k], ~tw[k]);
      rdchk(A_TW_LO, tw[k][31:0], 32'hFFFF_FFFF);
      rdchk(A_TW_HI, {16'h0, tw[k][47:32]}, 32'hFFFF_FFFF);
      rdchk(A_PO_LO, ~tw[k][31:0], 32'hFFFF_FFFF);
      rdchk(A_PO_HI, {16'h0, ~tw[k][47:32]}, 32'hFFFF_FFFF);
      rdchk(A_STATUS, {28'h0, sel}, 32'hF);
    end
    bus(1'b1, A_MA_LO, 32'h1);
    bus(1'b1, A_MB_LO, 32'h3);
    bus(1'b1, A_SOFTRST, 32'h1);
    rdchk(A_STATUS, 32'h80, 32'h80);
    bus(1'b1, A_MA_LO, 32'h0);
    bus(1'b1, A_SOFTRST, 32'h1);
    rdchk(A_STATUS, 32'h0, 32'h80);
    gsel <= 4'(rnd());
    bus(1'b1, A_NCOSEL, 32'h10);
    rdchk(A_STATUS, {28'h0, gsel}, 32'hF);
    $display("test tuning sets and select done");
    wset(4'h0, 48'h0, 48'h0);
    for (int g = 0; g < 2; g++) begin
      r = rnd();
      slow <= g[0];
      stream({26'h0, IF_ZERO, 3'b000, g[0]}, {{4{r[11]}}, r[11:0]},
             {{4{r[27]}}, r[27:16]}, 0);
    end
    slow <= 1'b0;
    stream({26'h0, IF_ZERO, 4'b1000}, 16'h2000, 16'h0, 3);
    rdchk(A_CTRL, 32'h18, 32'h3F);
    wset(4'h0, 48'h8000_0000_0000, 48'h0);
    stream({26'h0, IF_VARIABLE, 4'h0}, 16'h2000, 16'h0, 1);
    wset(4'h0, 48'h0, 48'h0);
    stream({26'h0, IF_VARIABLE, 4'h0}, 16'h2000, 16'h0, 2);
    stream({26'h0, IF_QUARTER, 4'h0}, 16'h2000, 16'h0, 1);
    stream({26'h0, IF_TEST, 4'h0}, 16'h0, 16'h0, 2);
    sysref <= 1'b1;
    repeat (4) @(posedge clk_i);
    sysref <= 1'b0;
    stream({26'h0, IF_ZERO, 4'h0}, 16'h0123, 16'hFEDC, 0);
    conclude();
  end
endmodule : test_ddc_nco_frequency_translation
